// *** rtl/pod_pkg.sv ***
// Constants, field positions and encodings for the pin override, debounce
// and over-current sequencer block.
// Assumes a 200 MHz bus clock and word-aligned AHB-Lite register access.
`default_nettype none
package pod_pkg;

  // Clock and documented time bases, with their derived cycle counts.
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned FINE_STEP_NS = 1000;
  localparam int unsigned MEDIUM_STEP_NS = 1000000;
  localparam int unsigned COARSE_STEP_NS = 10000000;
  localparam int unsigned SAMPLE_PERIOD_NS = 100000;
  localparam int unsigned FINE_STEP_CYC = FINE_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned MEDIUM_STEP_CYC = MEDIUM_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned COARSE_STEP_CYC = COARSE_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_WATCH = 10'h054;
  localparam logic [9:0] IDX_OVR_EN = 10'h055;
  localparam logic [9:0] IDX_OVR_STS = 10'h056;
  localparam logic [9:0] IDX_BULK = 10'h059;
  localparam logic [9:0] IDX_COMMIT = 10'h05a;
  localparam logic [9:0] IDX_BULK_UPD = 10'h05b;
  localparam logic [9:0] IDX_MASK0 = 10'h060;
  localparam logic [9:0] IDX_MASK1 = 10'h062;
  localparam logic [9:0] IDX_MASK2 = 10'h064;
  localparam logic [9:0] IDX_MASK3 = 10'h066;
  localparam logic [9:0] IDX_OVR_OUT = 10'h068;
  localparam logic [9:0] IDX_OVR_DIR = 10'h06a;
  localparam logic [9:0] IDX_CNT_COARSE = 10'h06c;
  localparam logic [9:0] IDX_CNT_MEDIUM = 10'h06d;
  localparam logic [9:0] IDX_CNT_FINE = 10'h06e;
  localparam logic [9:0] IDX_DB_STATE = 10'h06f;
  localparam logic [9:0] IDX_DB_SEL = 10'h070;
  localparam logic [9:0] IDX_CMP_CTL = 10'h080;
  localparam logic [9:0] IDX_CMP_MATCH = 10'h081;
  localparam logic [9:0] IDX_CMP_CHG = 10'h082;
  localparam logic [9:0] IDX_PIN_LEVEL = 10'h090;
  localparam logic [9:0] IDX_PIN_DIR = 10'h091;
  localparam logic [9:0] IDX_OVR_SRC = 10'h092;

  // Reset values.
  localparam logic [7:0] DB_COUNT_RST = 8'h0a;
  localparam logic [15:0] PIN16_RST = 16'h0000;
  localparam logic [31:0] DB_SEL_RST = 32'h0000_0000;

  // Field positions.
  localparam int unsigned CMP_RUN_BIT = 7;
  localparam int unsigned SRC_FIELD_STRIDE = 8;
  localparam logic [4:0] SRC_SENSE_ONE = 5'h10;
  localparam logic [4:0] SRC_SENSE_TWO = 5'h11;

  typedef enum logic [1:0] {
    DB_OFF = 2'b00,
    DB_FINE = 2'b01,
    DB_MEDIUM = 2'b10,
    DB_COARSE = 2'b11
  } pod_db_sel_t;

  typedef enum logic [1:0] {
    CMP_OFF = 2'b00,
    CMP_ONE = 2'b01,
    CMP_TWO = 2'b10,
    CMP_BOTH = 2'b11
  } pod_cmp_mode_t;

endpackage
`default_nettype wire

// *** rtl/pod_top.sv ***
// Pin override, per-pin debounce and over-current sample sequencer with an
// AHB-Lite register slave. Assumes pins and sense inputs are asynchronous
// and that the single slave's hreadyout is the bus hready.
//
// Overview of operation
// - bulk output write copies into pin levels
// - bulk update waits for upper-byte commit write
// - each override owns a sixteen-pin mask
// - several overrides may mask the same pin
// - triggered override drives shared override level
// - triggered override sets shared override direction
// - coarse base counts 10 ms steps, reset 0Ah
// - medium base counts 1 ms steps, reset 0Ah
// - fine base counts 1 us steps, reset 0Ah
// - transitions inside debounce period restart it
// - debounce length is count or count-1
// - pending bit shows any debounce in progress
// - two-bit select per pin picks base
// - comparator mode field selects sense inputs
// - single-input modes sample every 100 us
// - dual mode alternates, each input 200 us
// - control bit 7 shows sequencer running
// - match bits flag over-current per input
// - match cleared while its input not sampled
// - override triggers on watch level, clears on disable
// - watch level one means above threshold
// - match change sets flag, write one clears
`timescale 1ns/1ps
`default_nettype none
module pod_top #(
  parameter int unsigned MEDIUM_CYC = pod_pkg::MEDIUM_STEP_CYC,
  parameter int unsigned COARSE_CYC = pod_pkg::COARSE_STEP_CYC,
  parameter int unsigned SAMPLE_CYC = pod_pkg::SAMPLE_PERIOD_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] io_pin_in,
  output logic [15:0] io_pin_out,
  output logic [15:0] io_pin_oe_n,
  input wire logic sense_input_one,
  input wire logic sense_input_two
);
  import pod_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave. Every transfer completes with zero wait states.

  logic wr_q, rd_q;
  logic [9:0] idx_q;
  logic [31:0] rdata_q, rd_val;
  logic take;
  logic [9:0] addr_idx;

  assign take = hsel && hready && htrans[1];
  assign addr_idx = haddr[11:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= 10'h000;
    end else begin
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
      idx_q <= addr_idx;
    end
  end

  // Read data is latched at the address phase so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      rdata_q <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.

  logic [15:0] stage_q, bulk_q, bulk_upd_q, pin_level_q, pin_dir_q;
  logic [15:0] ovr_out_q, ovr_dir_q;
  logic [15:0] mask_q [4];
  logic [3:0] ovr_en_q, watch_q, act_q;
  logic [4:0] src_q [4];
  logic [7:0] cnt_coarse_q, cnt_medium_q, cnt_fine_q;
  logic [31:0] db_sel_q;
  logic [1:0] cmp_mode_q, match_q, match_d, chg_q;
  logic [15:0] commit_val;

  assign commit_val = {hwdata[7:0], stage_q[7:0]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_q <= PIN16_RST;
      bulk_q <= PIN16_RST;
      bulk_upd_q <= PIN16_RST;
      pin_level_q <= PIN16_RST;
      pin_dir_q <= PIN16_RST;
    end else if (wr_q) begin
      if (idx_q == IDX_BULK) begin
        stage_q <= hwdata[15:0];
      end
      if (idx_q == IDX_COMMIT) begin
        bulk_q <= commit_val;
        pin_level_q <= commit_val;
      end
      if (idx_q == IDX_BULK_UPD) begin
        bulk_upd_q <= hwdata[15:0];
      end
      if (idx_q == IDX_PIN_LEVEL) begin
        pin_level_q <= hwdata[15:0];
      end
      if (idx_q == IDX_PIN_DIR) begin
        pin_dir_q <= hwdata[15:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < 4; k++) begin
        mask_q[k] <= PIN16_RST;
        src_q[k] <= 5'h00;
      end
      ovr_out_q <= PIN16_RST;
      ovr_dir_q <= PIN16_RST;
      ovr_en_q <= 4'h0;
      watch_q <= 4'h0;
    end else if (wr_q) begin
      // Masks are independent, so one pin may sit in several.
      if (idx_q == IDX_MASK0) mask_q[0] <= hwdata[15:0];
      if (idx_q == IDX_MASK1) mask_q[1] <= hwdata[15:0];
      if (idx_q == IDX_MASK2) mask_q[2] <= hwdata[15:0];
      if (idx_q == IDX_MASK3) mask_q[3] <= hwdata[15:0];
      if (idx_q == IDX_OVR_OUT) ovr_out_q <= hwdata[15:0];
      if (idx_q == IDX_OVR_DIR) ovr_dir_q <= hwdata[15:0];
      if (idx_q == IDX_OVR_EN) ovr_en_q <= hwdata[3:0];
      if (idx_q == IDX_WATCH) watch_q <= hwdata[3:0];
      if (idx_q == IDX_OVR_SRC) begin
        for (int k = 0; k < 4; k++) begin
          src_q[k] <= hwdata[k*SRC_FIELD_STRIDE +: 5];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_coarse_q <= DB_COUNT_RST;
      cnt_medium_q <= DB_COUNT_RST;
      cnt_fine_q <= DB_COUNT_RST;
      db_sel_q <= DB_SEL_RST;
      cmp_mode_q <= CMP_OFF;
    end else if (wr_q) begin
      if (idx_q == IDX_CNT_COARSE) cnt_coarse_q <= hwdata[7:0];
      if (idx_q == IDX_CNT_MEDIUM) cnt_medium_q <= hwdata[7:0];
      if (idx_q == IDX_CNT_FINE) cnt_fine_q <= hwdata[7:0];
      if (idx_q == IDX_DB_SEL) db_sel_q <= hwdata;
      if (idx_q == IDX_CMP_CTL) cmp_mode_q <= hwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: a change counts once stages two and three agree.

  logic [17:0] raw_in, s1_q, s2_q, s3_q, st_q;

  assign raw_in = {sense_input_two, sense_input_one, io_pin_in};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 18'h00000;
      s2_q <= 18'h00000;
      s3_q <= 18'h00000;
      st_q <= 18'h00000;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= (s2_q & s3_q) | (st_q & (s2_q ^ s3_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time bases. Ticks are free running, so the first step of a debounce is
  // partial and the effective length is count or count-1.

  logic [31:0] fine_div_q, medium_div_q, coarse_div_q, smp_div_q;
  logic tick_fine, tick_medium, tick_coarse, smp_tick;

  assign tick_fine = fine_div_q == 32'(FINE_STEP_CYC - 1);
  assign tick_medium = medium_div_q == 32'(MEDIUM_CYC - 1);
  assign tick_coarse = coarse_div_q == 32'(COARSE_CYC - 1);
  assign smp_tick = smp_div_q == 32'(SAMPLE_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fine_div_q <= 32'h0000_0000;
      medium_div_q <= 32'h0000_0000;
      coarse_div_q <= 32'h0000_0000;
      smp_div_q <= 32'h0000_0000;
    end else begin
      fine_div_q <= tick_fine ? 32'h0000_0000 : fine_div_q + 32'h1;
      medium_div_q <= tick_medium ? 32'h0000_0000 : medium_div_q + 32'h1;
      coarse_div_q <= tick_coarse ? 32'h0000_0000 : coarse_div_q + 32'h1;
      smp_div_q <= smp_tick ? 32'h0000_0000 : smp_div_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin debouncers.

  logic [15:0] filt_w, busy_w;

  for (genvar i = 0; i < 16; i++) begin : g_db
    pod_db_sel_t sel;
    logic [7:0] load, cnt_q;
    logic tick, prev_q, filt_q, busy_q;

    assign sel = pod_db_sel_t'(db_sel_q[2*i +: 2]);
    always_comb begin
      load = cnt_fine_q;
      tick = tick_fine;
      unique case (sel)
        DB_OFF, DB_FINE: begin
          load = cnt_fine_q;
          tick = tick_fine;
        end
        DB_MEDIUM: begin
          load = cnt_medium_q;
          tick = tick_medium;
        end
        DB_COARSE: begin
          load = cnt_coarse_q;
          tick = tick_coarse;
        end
      endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        prev_q <= 1'b0;
        filt_q <= 1'b0;
        busy_q <= 1'b0;
        cnt_q <= 8'h00;
      end else begin
        prev_q <= st_q[i];
        if (sel == DB_OFF) begin
          filt_q <= st_q[i];
          busy_q <= 1'b0;
          cnt_q <= 8'h00;
        end else if (st_q[i] != prev_q) begin
          cnt_q <= load;
          busy_q <= 1'b1;
        end else if (busy_q && tick) begin
          if (cnt_q <= 8'h01) begin
            busy_q <= 1'b0;
            filt_q <= st_q[i];
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
      end
    end

    assign filt_w[i] = filt_q;
    assign busy_w[i] = busy_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Override functions and pin drive.

  logic [3:0] src_lvl;
  logic [15:0] hit_w;
  logic [15:0] drive_lvl, drive_dir;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (src_q[k] == SRC_SENSE_ONE) begin
        src_lvl[k] = st_q[16];
      end else if (src_q[k] == SRC_SENSE_TWO) begin
        src_lvl[k] = st_q[17];
      end else begin
        src_lvl[k] = filt_w[src_q[k][3:0]];
      end
    end
  end

  // Disable wins over a match: the flag only clears through the enable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= 4'h0;
    end else begin
      act_q <= ovr_en_q & (act_q | ~(src_lvl ^ watch_q));
    end
  end

  always_comb begin
    for (int p = 0; p < 16; p++) begin
      hit_w[p] = |(act_q & {mask_q[3][p], mask_q[2][p],
                            mask_q[1][p], mask_q[0][p]});
    end
    drive_lvl = (hit_w & ovr_out_q) | (~hit_w & pin_level_q);
    drive_dir = (hit_w & ovr_dir_q) | (~hit_w & pin_dir_q);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_pin_out <= 16'h0000;
      io_pin_oe_n <= 16'hffff;
    end else begin
      io_pin_out <= drive_lvl;
      io_pin_oe_n <= ~drive_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Over-current sample sequencer.

  logic phase_q;

  always_comb begin
    match_d = match_q;
    unique case (pod_cmp_mode_t'(cmp_mode_q))
      CMP_OFF: match_d = 2'b00;
      CMP_ONE: begin
        match_d[1] = 1'b0;
        if (smp_tick) match_d[0] = st_q[16];
      end
      CMP_TWO: begin
        match_d[0] = 1'b0;
        if (smp_tick) match_d[1] = st_q[17];
      end
      CMP_BOTH: begin
        if (smp_tick && !phase_q) match_d[0] = st_q[16];
        if (smp_tick && phase_q) match_d[1] = st_q[17];
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= 1'b0;
      match_q <= 2'b00;
    end else begin
      match_q <= match_d;
      if (cmp_mode_q != CMP_BOTH) begin
        phase_q <= 1'b0;
      end else if (smp_tick) begin
        phase_q <= !phase_q;
      end
    end
  end

  logic [1:0] chg_clr;

  assign chg_clr = (wr_q && idx_q == IDX_CMP_CHG) ? hwdata[1:0] : 2'b00;

  // A change in the same cycle as a clearing write still sets the flag.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chg_q <= 2'b00;
    end else begin
      chg_q <= (chg_q & ~chg_clr) | (match_d ^ match_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped indices read zero.

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (addr_idx)
      IDX_WATCH: rd_val = {28'h0, watch_q};
      IDX_OVR_EN: rd_val = {28'h0, ovr_en_q};
      IDX_OVR_STS: rd_val = {28'h0, act_q};
      IDX_BULK: rd_val = {16'h0, bulk_q};
      IDX_COMMIT: rd_val = {24'h0, bulk_q[15:8]};
      IDX_BULK_UPD: rd_val = {16'h0, bulk_upd_q};
      IDX_MASK0: rd_val = {16'h0, mask_q[0]};
      IDX_MASK1: rd_val = {16'h0, mask_q[1]};
      IDX_MASK2: rd_val = {16'h0, mask_q[2]};
      IDX_MASK3: rd_val = {16'h0, mask_q[3]};
      IDX_OVR_OUT: rd_val = {16'h0, ovr_out_q};
      IDX_OVR_DIR: rd_val = {16'h0, ovr_dir_q};
      IDX_CNT_COARSE: rd_val = {24'h0, cnt_coarse_q};
      IDX_CNT_MEDIUM: rd_val = {24'h0, cnt_medium_q};
      IDX_CNT_FINE: rd_val = {24'h0, cnt_fine_q};
      IDX_DB_STATE: rd_val = {31'h0, |busy_w};
      IDX_DB_SEL: rd_val = db_sel_q;
      IDX_CMP_CTL: rd_val = {24'h0, cmp_mode_q != CMP_OFF, 5'h00,
                             cmp_mode_q};
      IDX_CMP_MATCH: rd_val = {30'h0, match_q};
      IDX_CMP_CHG: rd_val = {30'h0, chg_q};
      IDX_PIN_LEVEL: rd_val = {16'h0, pin_level_q};
      IDX_PIN_DIR: rd_val = {16'h0, pin_dir_q};
      IDX_OVR_SRC: rd_val = {3'h0, src_q[3], 3'h0, src_q[2],
                             3'h0, src_q[1], 3'h0, src_q[0]};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  commit_copy_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (wr_q && idx_q == IDX_COMMIT) |=> pin_level_q == $past(commit_val))
    else $error("bulk commit did not reach pin levels");

  bulk_hold_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (wr_q && idx_q == IDX_BULK) |=> $stable(pin_level_q))
    else $error("bulk write changed pins before commit");

  ovr_drive_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    hit_w != 16'h0000 |=>
      ((io_pin_out ^ $past(ovr_out_q)) & $past(hit_w)) == 16'h0000 &&
      ((io_pin_oe_n ^ ~$past(ovr_dir_q)) & $past(hit_w)) == 16'h0000)
    else $error("override level or direction not driven");

  own_drive_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    hit_w != 16'hffff |=>
      ((io_pin_out ^ $past(pin_level_q)) & ~$past(hit_w)) == 16'h0000 &&
      ((io_pin_oe_n ^ ~$past(pin_dir_q)) & ~$past(hit_w)) == 16'h0000)
    else $error("own pin level or direction not driven");

  ovr_flag_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    ovr_en_q == 4'h0 |=> act_q == 4'h0)
    else $error("override flag held while disabled");

  db_settle_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    ($changed(filt_w[0]) && $past(db_sel_q[1:0]) != DB_OFF)
      |-> $past(busy_w[0]) && !busy_w[0])
    else $error("filtered pin changed outside debounce end");

  match_clear_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (cmp_mode_q == CMP_OFF || cmp_mode_q == CMP_TWO) |=> !match_q[0])
    else $error("match one set while not sampled");

  change_flag_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    $changed(match_q) |-> (chg_q & (match_q ^ $past(match_q))) != 2'b00)
    else $error("match change did not set flag");

  sample_tick_a: assert property (@(posedge hclk)
    disable iff (!hresetn)
    ($changed(match_q[0]) && $past(cmp_mode_q) == CMP_ONE) |-> $past(smp_tick))
    else $error("match sampled off the sample period");

  commit_c: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_q && idx_q == IDX_COMMIT);
  trigger_c: cover property (@(posedge hclk) disable iff (!hresetn)
    hit_w != 16'h0000);
  settle_c: cover property (@(posedge hclk) disable iff (!hresetn)
    $fell(busy_w[0]));
  dual_c: cover property (@(posedge hclk) disable iff (!hresetn)
    cmp_mode_q == CMP_BOTH && match_q == 2'b11);

endmodule
`default_nettype wire

// *** verification/pod_pins.sv ***
// Partner model: the components wired to the sixteen io pins.
// Assumes the bench commands each component's level through ext_level.
`timescale 1ns/1ps
`default_nettype none
module pod_pins (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic [15:0] ext_level,
  output logic [15:0] pin_in
);
  // A pin that the device drives reads back its own level, because the
  // push-pull driver overpowers the component; otherwise the component wins.
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule
`default_nettype wire

// *** verification/pod_top_tb.sv ***
// Self-checking bench for pod_top with an AHB-Lite master and pin partner.
// Assumes shortened time bases passed in as parameters.
`timescale 1ns/1ps
`default_nettype none
module pod_top_tb;
  import pod_pkg::*;
  localparam int unsigned MC = 20;
  localparam int unsigned CC = 40;
  localparam int unsigned SC = 16;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [15:0] pin_in, pin_out, pin_oe_n;
  logic [15:0] ext = 16'h0;
  logic s1 = 1'b0;
  logic s2 = 1'b0;
  int mismatches = 0;
  int n_tests = 0;
  int st;
  logic [31:0] rv;
  logic [15:0] v, lv, ovl, ovd;
  logic [15:0] mk [4];

  always #2.5 hclk = ~hclk;

  pod_top #(.MEDIUM_CYC(MC), .COARSE_CYC(CC), .SAMPLE_CYC(SC)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .io_pin_in(pin_in), .io_pin_out(pin_out), .io_pin_oe_n(pin_oe_n),
    .sense_input_one(s1), .sense_input_two(s2));

  pod_pins pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext),
    .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // A stuck hready would hang the master, so the wait is bounded.
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask

  task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, i, 2'b00};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask

  task automatic rc(input logic [9:0] i, input logic [31:0] exp);
    bus(1'b0, i, 32'h0);
    chk(rv, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Pin 0 is the only input; masks never include it.
  function automatic logic [31:0] pexp(input logic [15:0] m);
    return {(~ovd & m) | (16'h0001 & ~m), (ovl & m) | (lv & ~m)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rv = $urandom(32'h994c9b04);
    lv = 16'h0;
    cyc(2);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({pin_oe_n, pin_out}, 32'hffff_0000);
    rc(IDX_CNT_COARSE, {24'h0, DB_COUNT_RST});
    rc(IDX_CNT_MEDIUM, {24'h0, DB_COUNT_RST});
    rc(IDX_CNT_FINE, {24'h0, DB_COUNT_RST});
    rc(IDX_DB_SEL, DB_SEL_RST);
    rc(IDX_CMP_CTL, 32'h0);
    rc(IDX_CMP_MATCH, 32'h0);
    rc(10'h3ff, 32'h0);
    wr(IDX_PIN_DIR, 32'h0000_fffe);
    repeat (4) begin
      v = 16'($urandom);
      wr(IDX_BULK, {16'h0, v});
      cyc(4);
      chk(pin_out, lv);
      wr(IDX_COMMIT, {24'h0, v[15:8]});
      cyc(4);
      chk({pin_oe_n, pin_out}, {16'h0001, v});
      rc(IDX_BULK, {16'h0, v});
      lv = v;
    end
    v = 16'($urandom);
    wr(IDX_PIN_LEVEL, {16'h0, v});
    wr(IDX_BULK_UPD, {16'h0, ~v});
    chk({pin_oe_n, pin_out}, {16'h0001, v});
    rc(IDX_BULK_UPD, {16'h0, ~v});
    rc(IDX_BULK, {16'h0, lv});
    lv = v;
    ovl = 16'($urandom);
    ovd = 16'($urandom);
    wr(IDX_OVR_OUT, {16'h0, ovl});
    wr(IDX_OVR_DIR, {16'h0, ovd});
    wr(IDX_OVR_SRC, {3'h0, SRC_SENSE_TWO, 3'h0, SRC_SENSE_ONE, 16'h0});
    wr(IDX_WATCH, 32'hb);
    for (int k = 0; k < 4; k++) begin
      mk[k] = 16'($urandom) & 16'hfffe;
      wr(IDX_MASK0 + 10'(2 * k), {16'h0, mk[k]});
    end
    ext[0] <= 1'b1;
    s2 <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(IDX_OVR_EN, 32'(1 << k));
      cyc(4);
      rc(IDX_OVR_STS, 32'(1 << k));
      chk({pin_oe_n, pin_out}, pexp(mk[k]));
    end
    wr(IDX_OVR_EN, 32'h3);
    cyc(4);
    chk({pin_oe_n, pin_out}, pexp(mk[0] | mk[1]));
    wr(IDX_OVR_EN, 32'h0);
    cyc(4);
    rc(IDX_OVR_STS, 32'h0);
    chk({pin_oe_n, pin_out}, pexp(16'h0));
    wr(IDX_CNT_FINE, 32'h3);
    wr(IDX_CNT_MEDIUM, 32'h3);
    wr(IDX_CNT_COARSE, 32'h3);
    rc(IDX_CNT_FINE, 32'h3);
    for (int s = 1; s < 4; s++) begin
      st = (s == 1) ? int'(FINE_STEP_CYC) : (s == 2) ? MC : CC;
      wr(IDX_DB_SEL, 32'(s));
      ext[0] <= 1'b0;
      cyc(4 * st);
      wr(IDX_OVR_EN, 32'h1);
      ext[0] <= 1'b1;
      cyc(st / 2);
      ext[0] <= 1'b0;
      cyc(4 * st);
      rc(IDX_OVR_STS, 32'h0);
      ext[0] <= 1'b1;
      cyc(5);
      rc(IDX_DB_STATE, 32'h1);
      rc(IDX_OVR_STS, 32'h0);
      cyc(3 * st + 10);
      rc(IDX_OVR_STS, 32'h1);
      rc(IDX_DB_STATE, 32'h0);
      wr(IDX_OVR_EN, 32'h0);
    end
    s1 <= 1'b1;
    for (int md = 0; md < 4; md++) begin
      wr(IDX_CMP_CTL, 32'(md) | 32'h80);
      cyc(2 * SC + 8);
      rc(IDX_CMP_CTL, {24'h0, md != 0, 5'h0, 2'(md)});
      rc(IDX_CMP_MATCH, 32'(md));
    end
    rc(IDX_CMP_CHG, 32'h3);
    wr(IDX_CMP_CHG, 32'h1);
    rc(IDX_CMP_CHG, 32'h2);
    s1 <= 1'b0;
    cyc(2 * SC + 6);
    rc(IDX_CMP_MATCH, 32'h2);
    wr(IDX_CMP_CTL, 32'h1);
    s1 <= 1'b1;
    cyc(SC + 6);
    rc(IDX_CMP_MATCH, 32'h1);
    results();
  end
endmodule
`default_nettype wire
